/* rtl/board_reset_and_boot_overlay.sv */
`timescale 1ns/1ps
`include "board_reset_defines.svh"
module board_reset_and_boot_overlay #(
  parameter int unsigned POWERUP_CYCLES = `POWERUP_HOLD_CYCLES,
  parameter int unsigned SWITCH_CYCLES = `SWITCH_RELEASE_CYCLES,
  parameter int unsigned SOFT_CYCLES = `SOFT_RESET_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_switch_closed,
  input wire logic expansion_reset_in,
  input wire logic reset_instruction,
  input wire logic bus_read,
  input wire logic [`ADDR_W-1:0] bus_addr,
  input wire logic processor_halted,
  input wire logic floppy_side_select,
  input wire logic diag_override,
  input wire logic diag_override_value,
  output logic processor_reset,
  output logic peripheral_reset,
  output logic disk_interface_reset,
  output logic expansion_reset_out,
  output logic boot_overlay,
  output logic rom_select,
  output logic ram_select,
  output logic [`ADDR_W-1:0] rom_addr,
  output logic onboard_halt_lamp,
  output logic front_panel_indicator_header,
  output logic diagnostic_lamp
);
  logic switch_sync;
  logic expansion_sync;
  logic switch_hold;
  logic soft_hold;
  logic powerup_hold;
  logic hw_reset;
  logic any_reset;
  logic vector_read;
  logic low_hit;
  logic rom_hit;
  logic next_rom_select;
  logic next_ram_select;
  logic [`ADDR_W-1:0] next_rom_addr;
  board_reset_pkg::seq_state_t state;
  board_reset_pkg::seq_state_t next_state;

  // switch and expansion inputs brought onto the board clock
  level_sync #(.RESET_VALUE(1'b0)) u_sync_switch (
    .clk(clk),
    .srst(srst),
    .din(reset_switch_closed),
    .dout(switch_sync)
  );

  level_sync #(.RESET_VALUE(1'b0)) u_sync_expansion (
    .clk(clk),
    .srst(srst),
    .din(expansion_reset_in),
    .dout(expansion_sync)
  );

  // power-up hold: counter starts on the power-on srst
  stretch_counter #(.COUNT(POWERUP_CYCLES)) u_powerup (
    .clk(clk),
    .srst(srst),
    .trigger(1'b0),
    .active(powerup_hold)
  );

  // switch debounce: held while closed, released later; bounces just re-arm
  // not armed by srst, or every power-up would last as long as the switch delay
  stretch_counter #(.COUNT(SWITCH_CYCLES), .HOLD_AT_RESET(1'b0)) u_switch (
    .clk(clk),
    .srst(srst),
    .trigger(switch_sync),
    .active(switch_hold)
  );

  // software reset pulse; reset instruction is a strobe from the bus side
  stretch_counter #(.COUNT(SOFT_CYCLES), .HOLD_AT_RESET(1'b0)) u_soft (
    .clk(clk),
    .srst(srst),
    .trigger(reset_instruction && !powerup_hold),
    .active(soft_hold)
  );

  // the three hardware sources merge into one
  assign hw_reset = powerup_hold || switch_hold || expansion_sync;
  // software and hardware look alike to everything but the processor
  assign any_reset = hw_reset || soft_hold;

  // processor only sees hardware resets; released on a clock edge
  always_ff @(posedge clk) begin
    if (srst) begin
      processor_reset <= 1'b1;
    end else begin
      processor_reset <= hw_reset;
    end
  end

  // on-board peripherals see every cause, software included
  always_ff @(posedge clk) begin
    if (srst) begin
      peripheral_reset <= 1'b1;
    end else begin
      peripheral_reset <= any_reset;
    end
  end

  // disk interface reset output shares the peripheral cause, so drives restart with the board
  always_ff @(posedge clk) begin
    if (srst) begin
      disk_interface_reset <= 1'b1;
    end else begin
      disk_interface_reset <= any_reset;
    end
  end

  // expansion reset output; also driven when the port itself asked for the reset
  always_ff @(posedge clk) begin
    if (srst) begin
      expansion_reset_out <= 1'b1;
    end else begin
      expansion_reset_out <= any_reset;
    end
  end

  // decode terms for the overlay window
  assign low_hit = (bus_addr & `LOW_WINDOW_MASK) == 32'h0000_0000;
  assign rom_hit = (bus_addr & `LOW_WINDOW_MASK) == `ROM_BASE;
  assign vector_read = bus_read && (bus_addr == `VECTOR1_LOW);

  // reset -> overlay -> normal; overlay ends on the second vector read
  always_comb begin
    next_state = state;
    unique case (state)
      board_reset_pkg::ST_POWERUP: begin
        if (!any_reset) begin
          next_state = board_reset_pkg::ST_OVERLAY;
        end
      end
      board_reset_pkg::ST_RESET: begin
        if (!any_reset) begin
          next_state = board_reset_pkg::ST_OVERLAY;
        end
      end
      board_reset_pkg::ST_OVERLAY: begin
        if (any_reset) begin
          next_state = board_reset_pkg::ST_RESET;
        end else if (vector_read) begin
          next_state = board_reset_pkg::ST_NORMAL;
        end
      end
      board_reset_pkg::ST_NORMAL: begin
        if (any_reset) begin
          next_state = board_reset_pkg::ST_RESET;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= board_reset_pkg::ST_POWERUP;
    end else begin
      state <= next_state;
    end
  end

  // overlay flag seen by the memory decoder
  always_ff @(posedge clk) begin
    if (srst) begin
      boot_overlay <= 1'b1;
    end else begin
      boot_overlay <= (next_state != board_reset_pkg::ST_NORMAL);
    end
  end

  // decode uses the overlay flag as it stood, so the vector read itself still hits ROM
  always_comb begin
    next_rom_select = bus_read && (rom_hit || (boot_overlay && low_hit));
    next_ram_select = bus_read && low_hit && !boot_overlay;
    next_rom_addr = bus_addr;
    if (boot_overlay && low_hit) begin
      next_rom_addr = bus_addr | `ROM_BASE;
    end
  end

  // ROM select; ROM answers at its own base and, in overlay, in low memory
  always_ff @(posedge clk) begin
    if (srst) begin
      rom_select <= 1'b0;
    end else begin
      rom_select <= next_rom_select;
    end
  end

  // RAM select; RAM is never cleared by reset, only hidden
  always_ff @(posedge clk) begin
    if (srst) begin
      ram_select <= 1'b0;
    end else begin
      ram_select <= next_ram_select;
    end
  end

  // ROM address with low addresses moved up to the ROM base during overlay
  always_ff @(posedge clk) begin
    if (srst) begin
      rom_addr <= '0;
    end else begin
      rom_addr <= next_rom_addr;
    end
  end

  // on-board halt lamp
  always_ff @(posedge clk) begin
    if (srst) begin
      onboard_halt_lamp <= 1'b0;
    end else begin
      onboard_halt_lamp <= processor_halted;
    end
  end

  // off-board lamp from the same input and edge, so the two cannot drift apart
  always_ff @(posedge clk) begin
    if (srst) begin
      front_panel_indicator_header <= 1'b0;
    end else begin
      front_panel_indicator_header <= processor_halted;
    end
  end

  // firmware override wins for coded fault flashing
  always_ff @(posedge clk) begin
    if (srst) begin
      diagnostic_lamp <= 1'b0;
    end else begin
      diagnostic_lamp <= diag_override ? diag_override_value : floppy_side_select;
    end
  end
endmodule

/* rtl/board_reset_defines.svh */
`ifndef BOARD_RESET_DEFINES_SVH
`define BOARD_RESET_DEFINES_SVH

// board clock
`define CLK_PERIOD_NS 10
// manual switch release delay after opening
`define SWITCH_RELEASE_MS 500
`define SWITCH_RELEASE_CYCLES ((`SWITCH_RELEASE_MS * 1000000) / `CLK_PERIOD_NS)
// power-up hold, long enough for supplies and oscillator
`define POWERUP_HOLD_MS 100
`define POWERUP_HOLD_CYCLES ((`POWERUP_HOLD_MS * 1000000) / `CLK_PERIOD_NS)
// software reset pulse width sent to peripherals
`define SOFT_RESET_CYCLES 16
// address map
`define ADDR_W 32
`define ROM_BASE 32'h0080_0000
`define VECTOR1_LOW 32'h0000_0004
`define VECTOR1_ROM 32'h0080_0004
`define LOW_WINDOW_MASK 32'hFF80_0000

`endif

/* rtl/board_reset_pkg.sv */
package board_reset_pkg;
  typedef enum logic [1:0] {
    ST_POWERUP = 2'b00,
    ST_OVERLAY = 2'b01,
    ST_NORMAL = 2'b11,
    ST_RESET = 2'b10
  } seq_state_t;
endpackage

/* rtl/level_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser; first stage feeds only the second
module level_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic din,
  output logic dout
);
  logic meta;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= RESET_VALUE;
      dout <= RESET_VALUE;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

/* rtl/stretch_counter.sv */
`timescale 1ns/1ps
// holds active while trigger is high and for COUNT cycles after it falls
module stretch_counter #(
  parameter int unsigned COUNT = 16,
  parameter int W = $clog2(COUNT + 1),
  parameter bit HOLD_AT_RESET = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic trigger,
  output logic active
);
  logic [W-1:0] remaining;

  // srst arms the hold only where power-up needs it; other holds start idle
  always_ff @(posedge clk) begin
    if (srst) begin
      remaining <= HOLD_AT_RESET ? W'(COUNT) : '0;
    end else if (trigger) begin
      remaining <= W'(COUNT);
    end else if (remaining != '0) begin
      remaining <= remaining - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      active <= HOLD_AT_RESET;
    end else begin
      active <= trigger || (remaining > W'(1));
    end
  end
endmodule

/* bench/board_reset_monitor.sv */
`timescale 1ns/1ps
// watches reset fan-out, boot overlay and halt lamps at the top ports
module board_reset_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_instruction,
  input wire logic bus_read,
  input wire logic [31:0] bus_addr,
  input wire logic processor_halted,
  input wire logic processor_reset,
  input wire logic peripheral_reset,
  input wire logic disk_interface_reset,
  input wire logic expansion_reset_out,
  input wire logic boot_overlay,
  input wire logic rom_select,
  input wire logic ram_select,
  input wire logic [31:0] rom_addr,
  input wire logic onboard_halt_lamp,
  input wire logic front_panel_indicator_header
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  halt_lamp_a: assert property (1'b1 |=> onboard_halt_lamp == $past(processor_halted))
    else $error("halt lamp does not follow halted input");
  lamp_mirror_a: assert property (front_panel_indicator_header == onboard_halt_lamp)
    else $error("off-board lamp differs from on-board lamp");
  outs_alike_a: assert property (disk_interface_reset == peripheral_reset)
    else $error("disk reset differs from peripheral reset");
  exp_out_a: assert property (expansion_reset_out == peripheral_reset)
    else $error("expansion reset differs from peripheral reset");
  overlay_on_reset_a: assert property (peripheral_reset |-> boot_overlay)
    else $error("reset without boot overlay");
  soft_reset_a: assert property (reset_instruction && !processor_reset |-> ##2 peripheral_reset && boot_overlay)
    else $error("reset instruction did not reset board");
  vector_exit_a: assert property (boot_overlay && !peripheral_reset && bus_read && bus_addr == 32'h0000_0004
    |=> rom_select && rom_addr == 32'h0080_0004 ##1 !boot_overlay)
    else $error("second vector read mishandled");
  low_map_a: assert property (!peripheral_reset && bus_read && bus_addr[31:23] == 9'h000
    |=> rom_select == $past(boot_overlay) && ram_select == !$past(boot_overlay))
    else $error("low memory decoded wrongly");
endmodule

bind board_reset_and_boot_overlay board_reset_monitor mon (.clk, .srst, .reset_instruction, .bus_read,
  .bus_addr, .processor_halted, .processor_reset, .peripheral_reset, .disk_interface_reset,
  .expansion_reset_out, .boot_overlay, .rom_select, .ram_select, .rom_addr, .onboard_halt_lamp,
  .front_panel_indicator_header);

/* bench/host_cpu_model.sv */
`timescale 1ns/1ps
// processor side: reset instruction pulses and single read cycles
module host_cpu_model (
  input wire logic clk,
  output logic reset_instruction,
  output logic bus_read,
  output logic [31:0] bus_addr
);
  initial begin
    reset_instruction = 1'b0;
    bus_read = 1'b0;
    bus_addr = 32'h5A5A_5A5A;
  end
  // only issued from rom code, the caller follows it with the vector read
  task reset_pulse;
    @(posedge clk) reset_instruction <= 1'b1;
    @(posedge clk) reset_instruction <= 1'b0;
  endtask
  // address flips to its inverse after the cycle so a stale value never looks valid
  task rd(input logic [31:0] a);
    @(posedge clk) begin bus_read <= 1'b1; bus_addr <= a; end
    @(posedge clk) begin bus_read <= 1'b0; bus_addr <= ~a; end
  endtask
endmodule

/* bench/board_reset_and_boot_overlay_bench.sv */
`timescale 1ns/1ps
module board_reset_and_boot_overlay_bench;
  localparam int PWR = 20;
  localparam int SW = 30;
  logic clk = 0, srst = 1, swc = 0, expi = 0, halted = 0, side = 0, dov = 0, dval = 0;
  logic instr, rd, pr, per, disk, expo, ovl, rsel, msel, lamp, front, diag;
  logic [31:0] addr, raddr;
  int miscompares = 0, total_checks = 0, n;
  initial forever #5 clk = ~clk;
  host_cpu_model cpu (.clk(clk), .reset_instruction(instr), .bus_read(rd), .bus_addr(addr));
  board_reset_and_boot_overlay #(.POWERUP_CYCLES(PWR), .SWITCH_CYCLES(SW), .SOFT_CYCLES(16)) uut (
    .clk(clk), .srst(srst), .reset_switch_closed(swc), .expansion_reset_in(expi),
    .reset_instruction(instr), .bus_read(rd), .bus_addr(addr), .processor_halted(halted),
    .floppy_side_select(side), .diag_override(dov), .diag_override_value(dval),
    .processor_reset(pr), .peripheral_reset(per), .disk_interface_reset(disk),
    .expansion_reset_out(expo), .boot_overlay(ovl), .rom_select(rsel), .ram_select(msel),
    .rom_addr(raddr), .onboard_halt_lamp(lamp), .front_panel_indicator_header(front),
    .diagnostic_lamp(diag));
  task end_sim;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task ticks(input int k);
    repeat (k) @(posedge clk);
  endtask
  // bounded wait for processor (sel) or peripheral reset to drop, counting edges
  task wait_low(input bit sel);
    for (n = 1; n < 200; n++) begin
      @(posedge clk);
      #1;
      if ((sel ? pr : per) === 1'b0) return;
    end
    miscompares++;
    end_sim;
  endtask
  // overlay read, vector read, then a normal-mapped read
  task vec_read;
    cpu.rd(32'h0000_0010);
    #1 chk({rsel, ovl, raddr}, {2'b11, 32'h0080_0010});
    cpu.rd(32'h0000_0004);
    #1 chk({rsel, ovl, raddr}, {2'b10, 32'h0080_0004});
    cpu.rd(32'h0000_0010);
    #1 chk(34'({rsel, msel, ovl}), 34'h2);
  endtask
  task t_hard(input bit use_sw);
    @(posedge clk) begin swc <= use_sw; expi <= !use_sw; end
    ticks(6);
    #1 chk(34'({pr, per, disk, expo, ovl}), 34'h1F);
    @(posedge clk) begin swc <= 0; expi <= 0; end
    wait_low(1);
    if (use_sw) chk(34'(n >= SW && n <= SW + 8), 34'h1);
    wait_low(0);
    vec_read;
  endtask
  task t_soft;
    cpu.reset_pulse;
    ticks(2);
    #1 chk(34'({pr, per, disk, expo, ovl}), 34'h0F);
    wait_low(0);
    chk(34'({pr, 1'(n >= 10 && n <= 18)}), 34'h1);
    vec_read;
  endtask
  task t_lamps;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) begin halted <= i[0]; side <= i[1]; end
      ticks(2);
      #1 chk(34'({lamp, front, diag}), 34'({i[0], i[0], i[1]}));
    end
    @(posedge clk) begin dov <= 1; dval <= 0; end
    ticks(2);
    #1 chk(34'(diag), 34'h0);
    @(posedge clk) begin dval <= 1; side <= 0; end
    ticks(2);
    #1 chk(34'(diag), 34'h1);
  endtask
  initial begin
    ticks(3);
    #1 chk(34'({pr, per, disk, expo, ovl}), 34'h1F);
    @(posedge clk) srst <= 0;
    wait_low(1);
    chk(34'(n >= PWR - 2 && n <= PWR + 2), 34'h1);
    wait_low(0);
    vec_read;
    t_hard(1);
    t_hard(0);
    t_soft;
    t_lamps;
    end_sim;
  end
endmodule
